// File: ccr_dev.sv
// Module: register end of the clock and alignment configuration link
//
// Chosen here: the serial link port.
`default_nettype none
module ccr_dev (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  ccr_link_if.dev LINK,
  input wire logic ALIGN_PULSE_IN,
  input wire logic [23:0] ALIGN_EDGE_POSITION,
  output logic ALIGN_EVENT,
  output logic ALIGN_RECEIVER_ENABLE,
  output logic ALIGN_FINE_STEP,
  output logic [3:0] ALIGN_DELAY_SELECT,
  output logic SAMPLE_CLOCK_PECL_MODE,
  output logic ALIGN_INPUT_PECL_MODE,
  output logic ANALOG_RAIL_QUIET_ENABLE,
  output logic CLOCK_RAIL_QUIET_ENABLE
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr_order;
    logic [7:0] user_port_config;
    logic [7:0] clock_control_first;
    logic [7:0] clock_control_second;
    logic [7:0] clock_control_third;
    ccr_pkg::ccr_phase_e phase;
    logic is_read;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [6:0] addr;
    logic [7:0] out_byte;
    logic sclk_last;
    logic event_out;
  } ccr_dev_s;

  ccr_dev_s st_reg;
  ccr_dev_s st_next;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] rd_byte;
  logic [7:0] in_byte;
  logic [23:0] pos_now;

  // Edge detect on the link clock, sampled as an ordinary input
  assign sclk_rise = LINK.sclk & ~st_reg.sclk_last;
  assign sclk_fall = ~LINK.sclk & st_reg.sclk_last;
  assign in_byte = {st_reg.shift[6:0], LINK.sdi};
  assign pos_now = ALIGN_EDGE_POSITION;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped addresses read zero
  always_comb begin
    unique case (st_reg.addr)
      ccr_pkg::OFS_ADDR_ORDER: rd_byte = st_reg.addr_order | ccr_pkg::MASK_ADDR_ORDER;
      ccr_pkg::OFS_USER_PORT: rd_byte = st_reg.user_port_config;
      ccr_pkg::OFS_CLK_FIRST: rd_byte = st_reg.clock_control_first;
      ccr_pkg::OFS_CLK_SECOND: rd_byte = st_reg.clock_control_second;
      ccr_pkg::OFS_CLK_THIRD: rd_byte = st_reg.clock_control_third;
      ccr_pkg::OFS_POS_LOW: rd_byte = pos_now[7:0];
      ccr_pkg::OFS_POS_MID: rd_byte = pos_now[15:8];
      ccr_pkg::OFS_POS_HIGH: rd_byte = pos_now[23:16];
      default: rd_byte = ccr_pkg::BYTE_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Mode 0 framing: sample on rise, shift out on fall
  always_comb begin
    st_next = st_reg;
    st_next.sclk_last = LINK.sclk;
    // Processor disabled drops every event; receiver off blocks input too
    st_next.event_out = st_reg.clock_control_first[ccr_pkg::BIT_PROC_EN]
      & st_reg.clock_control_first[ccr_pkg::BIT_RECV_EN]
      & (ALIGN_PULSE_IN ^ st_reg.clock_control_second[ccr_pkg::BIT_INVERT]);
    if (LINK.sel_n) begin
      st_next.phase = ccr_pkg::CCR_IDLE;
      st_next.bit_cnt = ccr_pkg::BIT_ZERO;
    end else begin
      if (st_reg.phase == ccr_pkg::CCR_IDLE) begin
        st_next.phase = ccr_pkg::CCR_ADDR;
      end
      if (sclk_rise) begin
        st_next.shift = in_byte;
        st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        if (st_reg.bit_cnt == ccr_pkg::BYTE_BITS - 4'h1) begin
          st_next.bit_cnt = ccr_pkg::BIT_ZERO;
          if (st_reg.phase != ccr_pkg::CCR_DATA) begin
            st_next.is_read = |(in_byte & ccr_pkg::CMD_READ_MASK);
            st_next.addr = in_byte[6:0];
            st_next.phase = ccr_pkg::CCR_DATA;
          end else begin
            if (!st_reg.is_read) begin
              unique case (st_reg.addr)
                ccr_pkg::OFS_ADDR_ORDER: st_next.addr_order = in_byte;
                ccr_pkg::OFS_USER_PORT: st_next.user_port_config = in_byte;
                ccr_pkg::OFS_CLK_FIRST: st_next.clock_control_first = in_byte;
                ccr_pkg::OFS_CLK_SECOND: st_next.clock_control_second = in_byte;
                ccr_pkg::OFS_CLK_THIRD: st_next.clock_control_third = in_byte;
                default: ;
              endcase
            end
            // Streaming address step, frozen by the user port bit
            if (!st_reg.user_port_config[ccr_pkg::BIT_ADDR_FREEZE]) begin
              if (st_reg.addr_order[ccr_pkg::BIT_ASCEND]) begin
                st_next.addr = st_reg.addr + ccr_pkg::ADDR_ONE;
              end else begin
                st_next.addr = st_reg.addr - ccr_pkg::ADDR_ONE;
              end
            end
          end
        end
      end
      // Load read byte on the fall that starts a data byte
      if (sclk_fall && st_reg.phase == ccr_pkg::CCR_DATA) begin
        if (st_reg.bit_cnt == ccr_pkg::BIT_ZERO) begin
          st_next.out_byte = rd_byte;
        end else begin
          st_next.out_byte = {st_reg.out_byte[6:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      st_reg <= '0;
      st_reg.addr_order <= ccr_pkg::RST_ADDR_ORDER;
      st_reg.user_port_config <= ccr_pkg::RST_USER_PORT;
      st_reg.clock_control_first <= ccr_pkg::RST_CLK_FIRST;
      st_reg.clock_control_second <= ccr_pkg::RST_CLK_SECOND;
      st_reg.clock_control_third <= ccr_pkg::RST_CLK_THIRD;
      st_reg.phase <= ccr_pkg::CCR_IDLE;
    end else if (CLK_EN) begin
      st_reg <= st_next;
    end
  end

  // Field outputs straight from the register bits
  assign LINK.sdo = st_reg.out_byte[7];
  assign ALIGN_EVENT = st_reg.event_out;
  assign ALIGN_RECEIVER_ENABLE = st_reg.clock_control_first[ccr_pkg::BIT_RECV_EN];
  assign ALIGN_FINE_STEP = st_reg.clock_control_first[ccr_pkg::BIT_FINE];
  assign ALIGN_DELAY_SELECT = st_reg.clock_control_first[3:0];
  assign SAMPLE_CLOCK_PECL_MODE = st_reg.clock_control_second[ccr_pkg::BIT_SAMPLE_PECL];
  assign ALIGN_INPUT_PECL_MODE = st_reg.clock_control_second[ccr_pkg::BIT_ALIGN_PECL];
  assign ANALOG_RAIL_QUIET_ENABLE = st_reg.clock_control_third[ccr_pkg::BIT_ANALOG_QUIET];
  assign CLOCK_RAIL_QUIET_ENABLE = st_reg.clock_control_third[ccr_pkg::BIT_CLOCK_QUIET];
endmodule : ccr_dev
`default_nettype wire

// File: ccr_pkg.sv
// Package: register map, field positions and link constants of the clock config block
`default_nettype none
package ccr_pkg;
  localparam logic [6:0] OFS_ADDR_ORDER = 7'h00;
  localparam logic [6:0] OFS_USER_PORT = 7'h10;
  localparam logic [6:0] OFS_CLK_FIRST = 7'h29;
  localparam logic [6:0] OFS_CLK_SECOND = 7'h2a;
  localparam logic [6:0] OFS_CLK_THIRD = 7'h2b;
  localparam logic [6:0] OFS_POS_LOW = 7'h2c;
  localparam logic [6:0] OFS_POS_MID = 7'h2d;
  localparam logic [6:0] OFS_POS_HIGH = 7'h2e;
  localparam logic [7:0] RST_ADDR_ORDER = 8'h30;
  localparam logic [7:0] RST_USER_PORT = 8'h00;
  localparam logic [7:0] RST_CLK_FIRST = 8'h80;
  localparam logic [7:0] RST_CLK_SECOND = 8'h00;
  localparam logic [7:0] RST_CLK_THIRD = 8'h10;
  localparam logic [7:0] MASK_ADDR_ORDER = 8'h10;
  localparam int BIT_ASCEND = 5;
  localparam int BIT_ADDR_FREEZE = 0;
  localparam int BIT_PROC_EN = 6;
  localparam int BIT_RECV_EN = 5;
  localparam int BIT_FINE = 4;
  localparam int BIT_SAMPLE_PECL = 2;
  localparam int BIT_ALIGN_PECL = 1;
  localparam int BIT_INVERT = 0;
  localparam int BIT_ANALOG_QUIET = 2;
  localparam int BIT_CLOCK_QUIET = 0;
  localparam int ADDR_W = 7;
  localparam int POS_W = 24;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ADDR_BITS = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [6:0] ADDR_ONE = 7'h01;
  localparam logic [7:0] CMD_READ_MASK = 8'h80;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic [1:0] {
    CCR_IDLE = 2'b00,
    CCR_ADDR = 2'b01,
    CCR_DATA = 2'b10
  } ccr_phase_e;
endpackage : ccr_pkg
`default_nettype wire

// File: ccr_link_if.sv
// Interface: serial link between the host controller and the register end
`default_nettype none
interface ccr_link_if;
  logic sel_n;
  logic sclk;
  logic sdi;
  logic sdo;
  modport host (output sel_n, output sclk, output sdi, input sdo);
  modport dev (input sel_n, input sclk, input sdi, output sdo);
endinterface : ccr_link_if
`default_nettype wire

// File: ccr_host.sv
// Module: host controller that runs one-byte register transfers over the link
`default_nettype none
module ccr_host (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  ccr_link_if.host LINK,
  input wire logic [1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Word 0: {read, addr[6:0], data[7:0]} starts a transfer; word 1: status
  typedef struct packed {
    logic busy;
    logic [4:0] bit_cnt;
    logic phase_hi;
    logic [15:0] shift;
    logic [7:0] rx;
    logic [7:0] rdata;
    logic sel_n;
    logic sclk;
  } ccr_host_s;

  ccr_host_s st_reg;
  ccr_host_s st_next;

  // Sclk toggles every two cycles: 4 system clocks per bit, device sees both edges
  always_comb begin
    st_next = st_reg;
    st_next.rdata = ccr_pkg::BYTE_ZERO;
    if (RD) begin
      st_next.rdata = (ADDR == 2'h1) ? {6'h00, st_reg.busy, 1'b0} : st_reg.rx;
    end
    if (WR && ADDR == 2'h0 && !st_reg.busy) begin
      st_next.busy = 1'b1;
      st_next.shift = WDATA;
      st_next.bit_cnt = 5'h00;
      st_next.phase_hi = 1'b0;
      st_next.sel_n = 1'b0;
      st_next.sclk = 1'b0;
    end else if (st_reg.busy) begin
      st_next.phase_hi = ~st_reg.phase_hi;
      if (st_reg.phase_hi) begin
        st_next.sclk = ~st_reg.sclk;
        if (st_reg.sclk) begin
          st_next.shift = {st_reg.shift[14:0], 1'b0};
          st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
          if (st_reg.bit_cnt == 5'h0f) begin
            st_next.busy = 1'b0;
            st_next.sel_n = 1'b1;
          end
        end else begin
          st_next.rx = {st_reg.rx[6:0], LINK.sdo};
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      st_reg <= '0;
      st_reg.sel_n <= 1'b1;
    end else if (CLK_EN) begin
      st_reg <= st_next;
    end
  end

  assign LINK.sel_n = st_reg.sel_n;
  assign LINK.sclk = st_reg.sclk;
  assign LINK.sdi = st_reg.shift[15];
  assign RDATA = st_reg.rdata;
endmodule : ccr_host
`default_nettype wire

// File: ccr_chk.sv
// Checker: framing and timing of the serial link wires between both ends
`default_nettype none
module ccr_chk (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo
);
  typedef struct packed {logic d; logic [7:0] low; logic [5:0] ris;} ccr_cnt_s;
  ccr_cnt_s c_reg;
  ccr_cnt_s c_next;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // Frame length and clock rises; cleared between frames so a short frame shows
  always_comb begin
    c_next = c_reg;
    c_next.d = sclk;
    c_next.low = sel_n ? 8'h00 : c_reg.low + 8'h01;
    c_next.ris = sel_n ? 6'h00 : c_reg.ris + 6'(sclk && !c_reg.d);
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end
  a_idle_clk_low: assert property (sel_n |-> !sclk)
    else $error("link clock moved outside a frame");
  a_high_half: assert property ($rose(sclk) |-> sclk [*2] ##1 !sclk)
    else $error("link clock high phase not two cycles");
  a_low_half: assert property ($fell(sclk) |-> !sclk [*2])
    else $error("link clock low phase too short");
  a_frame_start: assert property ($fell(sel_n) |-> !sclk [*2] ##1 sclk)
    else $error("first link clock rise misplaced");
  a_frame_len: assert property ($rose(sel_n) |-> c_reg.low == 8'h40)
    else $error("frame not 64 cycles long");
  a_bit_count: assert property ($rose(sel_n) |-> c_reg.ris == 6'h10)
    else $error("frame not 16 clock rises");
  a_data_steady: assert property (sclk && c_reg.d |-> $stable(sdi))
    else $error("host data moved while link clock high");
  a_reset_idle: assert property ($rose(RESET_N) |-> sel_n && !sclk && !sdo)
    else $error("link not idle after reset");
endmodule : ccr_chk
`default_nettype wire

// File: tb_clock_sysref_config_regs.sv
// Testbench: host and register end joined over the link, checked against a model
`default_nettype none
module tb_clock_sysref_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pulse = 1'b0;
  logic [23:0] pos = 24'h000000;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [7:0] v;
  logic [31:0] r;
  logic evt;
  logic [9:0] pins;
  logic [6:0] amap [9] = '{7'h00, 7'h10, 7'h29, 7'h2a, 7'h2b, 7'h2c, 7'h2d, 7'h2e, 7'h05};
  int n_fail = 0;
  int cmp_count = 0;
  int mdl [128];
  ccr_link_if u_ccr_link_if ();
  ccr_host u_ccr_host (.CLK_SYS(clk), .RESET_N(rst_n), .CLK_EN(clk_en), .LINK(u_ccr_link_if),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
  ccr_dev u_ccr_dev (.CLK_SYS(clk), .RESET_N(rst_n), .CLK_EN(clk_en), .LINK(u_ccr_link_if),
    .ALIGN_PULSE_IN(pulse), .ALIGN_EDGE_POSITION(pos), .ALIGN_EVENT(evt),
    .ALIGN_RECEIVER_ENABLE(pins[9]), .ALIGN_FINE_STEP(pins[8]), .ALIGN_DELAY_SELECT(pins[7:4]),
    .SAMPLE_CLOCK_PECL_MODE(pins[3]), .ALIGN_INPUT_PECL_MODE(pins[2]),
    .ANALOG_RAIL_QUIET_ENABLE(pins[1]), .CLOCK_RAIL_QUIET_ENABLE(pins[0]));
  ccr_chk u_ccr_chk (.CLK_SYS(clk), .RESET_N(rst_n), .sel_n(u_ccr_link_if.sel_n),
    .sclk(u_ccr_link_if.sclk), .sdi(u_ccr_link_if.sdi), .sdo(u_ccr_link_if.sdo));
  // Free-running system clock, 20 ns period
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One strobe cycle; read data is taken in the single cycle where it stands
  task automatic bus(input logic [1:0] a, input logic w, input logic [15:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus
  // Whole link transfer; busy is polled under a bound so a hang is caught
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] x);
    int n;
    bus(2'h0, 1'b1, {rw, a, x});
    n = 0;
    do begin
      bus(2'h1, 1'b0, 16'h0000);
      n++;
    end while (d[1] !== 1'b0 && n < 200);
    chk(16'(n < 200), 16'h0001);
    bus(2'h0, 1'b0, 16'h0000);
  endtask : xfer
  // Model keeps only mapped writable places; bit 4 at 0x00 always reads one
  task automatic wreg(input logic [6:0] a, input logic [7:0] x);
    xfer(1'b0, a, x);
    if (a inside {7'h10, 7'h29, 7'h2a, 7'h2b}) mdl[a] = x;
    if (a == 7'h00) mdl[a] = x | 8'h10;
  endtask : wreg
  task automatic rreg(input logic [6:0] a);
    xfer(1'b1, a, 8'h00);
    chk({8'h00, d}, mdl[a][15:0]);
  endtask : rreg
  task automatic sweep;
    foreach (amap[i]) rreg(amap[i]);
    v = 8'(mdl[41]);
    r = mdl[42] * 256 + mdl[43];
    chk({6'h00, pins}, {6'h00, v[5:0], r[10:9], r[2], r[0]});
  endtask : sweep
  task automatic do_reset;
    // Reset is driven on a rising edge like every other input
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (mdl[i]) mdl[i] = 0;
    mdl[0] = 48;
    mdl[41] = 128;
    mdl[43] = 16;
    mdl[44] = pos[7:0];
    mdl[45] = pos[15:8];
    mdl[46] = pos[23:16];
  endtask : do_reset
  // Watchdog: about 110 transfers of under 100 cycles each; 20k cycles is ample
  initial begin
    #400000;
    n_fail++;
    close_out();
  end
  initial begin
    void'($urandom(32050));
    r = $urandom();
    pos = r[23:0];
    do_reset();
    sweep();
    // Random legal values: reserved bits at defaults except bit 4 at 0x00 (written zero), receiver set with processor
    repeat (4) begin
      foreach (amap[i]) begin
        r = $urandom();
        case (i)
          0: v = {2'h0, r[5], 5'h00};
          1: v = {7'h00, r[0]};
          2: v = {1'b1, r[6], r[6] | r[5], r[4:0]};
          3: v = {5'h00, r[2:0]};
          default: v = {3'h0, 1'b1, 1'b0, r[2], 1'b0, r[0]};
        endcase
        wreg(amap[i], v);
      end
      sweep();
    end
    // Event gate: processor only ever set with the receiver, as the host must
    for (int i = 0; i < 8; i++) begin
      wreg(7'h29, {1'b1, i[2] & i[1], i[1], 5'h00});
      wreg(7'h2a, {7'h00, i[0]});
      for (int p = 0; p < 2; p++) begin
        @(posedge clk);
        pulse <= p[0];
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, evt}, 16'(i[2] & i[1] & (p[0] ^ i[0])));
      end
    end
    do_reset();
    sweep();
    close_out();
  end
endmodule : tb_clock_sysref_config_regs
`default_nettype wire
